/* pmc_map.svh */
// register offsets, field positions, reset values and timing counts for the mode control block
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

`define PMC_ADDR_CTRL 5'h00
`define PMC_ADDR_PAGE 5'h1F
`define PMC_PAGE_MAIN 16'h0000

`define PMC_B_SRST 15
`define PMC_B_LOOP 14
`define PMC_B_SPD_LSB 13
`define PMC_B_ANEG 12
`define PMC_B_PDOWN 11
`define PMC_B_ISO 10
`define PMC_B_RESTART 9
`define PMC_B_DUPLEX 8
`define PMC_B_COLTEST 7
`define PMC_B_SPD_MSB 6
`define PMC_B_UNIDIR 5

`define PMC_CTRL_RST 16'h1040
`define PMC_CTRL_WMASK 16'h7DE0

`define PMC_CLK_PERIOD_NS 10
`define PMC_SRST_WAIT_NS 1000
`define PMC_SRST_CYC ((`PMC_SRST_WAIT_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)

`endif

/* pmc_mdio_slave.sv */
// serial management interface slave: frame decode, register write strobe, read shift-out
`timescale 1ns/1ps
module pmc_mdio_slave (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic [4:0] phy_addr_i,
    input wire logic [15:0] rd_data_i,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    output logic [4:0] reg_addr_o,
    output logic wr_stb_o,
    output logic [15:0] wr_data_o
);
    logic [2:0] mdc_s_r;
    logic [2:0] mdio_s_r;
    logic mdc_lvl_r;
    logic mdio_lvl_r;
    pmc_pkg::pmc_mdio_st_t st_r;
    logic [3:0] cnt_r;
    logic [15:0] sh_r;
    logic prev_r;
    logic is_rd_r;
    logic match_r;
    logic [4:0] addr_r;
    logic oe_n_r;
    logic out_r;
    logic wr_stb_r;
    logic [15:0] wr_data_r;

    wire mdc_agree = (mdc_s_r[1] == mdc_s_r[2]);
    wire mdio_agree = (mdio_s_r[1] == mdio_s_r[2]);
    wire mdc_rise = mdc_agree && mdc_s_r[2] && !mdc_lvl_r;
    wire bit_in = mdio_agree ? mdio_s_r[2] : mdio_lvl_r;
    wire [11:0] hdr = {sh_r[10:0], bit_in};
    wire hdr_rd = (hdr[11:10] == 2'h2);
    wire hdr_wr = (hdr[11:10] == 2'h1);
    wire hdr_match = (hdr[9:5] == phy_addr_i) && (hdr_rd || hdr_wr);

    // pins cross in through three flops; a level counts once stages two and three agree
    always_ff @(posedge ref_clk_i) begin
        mdc_s_r <= {mdc_s_r[1:0], mdc_i};
        mdio_s_r <= {mdio_s_r[1:0], mdio_i};
        if (srst_i) begin
            mdc_lvl_r <= 1'b0;
            mdio_lvl_r <= 1'b1;
        end else begin
            if (mdc_agree) mdc_lvl_r <= mdc_s_r[2];
            if (mdio_agree) mdio_lvl_r <= mdio_s_r[2];
        end
    end

    // frames without a preamble are accepted, so preamble suppression works
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_r <= pmc_pkg::PMC_ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 16'h0000;
            prev_r <= 1'b1;
            is_rd_r <= 1'b0;
            match_r <= 1'b0;
            addr_r <= 5'h00;
            oe_n_r <= 1'b1;
            out_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_data_r <= 16'h0000;
        end else begin
            wr_stb_r <= 1'b0;
            if (mdc_rise) begin
                unique case (st_r)
                    pmc_pkg::PMC_ST_IDLE: begin
                        prev_r <= bit_in;
                        cnt_r <= 4'h0;
                        if (!prev_r && bit_in) st_r <= pmc_pkg::PMC_ST_HDR;
                    end
                    pmc_pkg::PMC_ST_HDR: begin
                        sh_r <= {sh_r[14:0], bit_in};
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == 4'hB) begin
                            addr_r <= hdr[4:0];
                            is_rd_r <= hdr_rd;
                            match_r <= hdr_match;
                            cnt_r <= 4'h0;
                            st_r <= pmc_pkg::PMC_ST_TA;
                        end
                    end
                    pmc_pkg::PMC_ST_TA: begin
                        cnt_r <= 4'h1;
                        if (cnt_r == 4'h0) begin
                            sh_r <= rd_data_i;
                            if (match_r && is_rd_r) begin
                                oe_n_r <= 1'b0;
                                out_r <= 1'b0;
                            end
                        end else begin
                            cnt_r <= 4'h0;
                            st_r <= pmc_pkg::PMC_ST_DATA;
                            out_r <= sh_r[15];
                            sh_r <= {sh_r[14:0], bit_in};
                        end
                    end
                    pmc_pkg::PMC_ST_DATA: begin
                        cnt_r <= cnt_r + 4'h1;
                        out_r <= sh_r[15];
                        sh_r <= {sh_r[14:0], bit_in};
                        if (cnt_r == 4'hF) begin
                            oe_n_r <= 1'b1;
                            prev_r <= 1'b1;
                            st_r <= pmc_pkg::PMC_ST_IDLE;
                            if (match_r && !is_rd_r) begin
                                wr_stb_r <= 1'b1;
                                wr_data_r <= {sh_r[14:0], bit_in};
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign mdio_o = out_r;
    assign mdio_oe_n_o = oe_n_r;
    assign reg_addr_o = addr_r;
    assign wr_stb_o = wr_stb_r;
    assign wr_data_o = wr_data_r;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    drive_only_read_a: assert property (!mdio_oe_n_o |-> is_rd_r && match_r)
        else $error("management pin driven outside an addressed read");

endmodule : pmc_mdio_slave

/* pmc_mode_ctrl.sv */
// mode control register of one phy port, with its effect on the mac-side path
`timescale 1ns/1ps
`include "pmc_map.svh"
module pmc_mode_ctrl #(
    parameter int DATA_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    input wire logic [4:0] phy_addr_i,
    input wire pmc_pkg::pmc_media_t media_mode_i,
    input wire logic link_up_i,
    input wire logic mac_tx_en_i,
    input wire logic [DATA_W-1:0] mac_txd_i,
    input wire logic media_col_i,
    input wire logic [DATA_W-1:0] media_rxd_i,
    output logic loopback_o,
    output pmc_pkg::pmc_speed_t speed_o,
    output logic aneg_en_o,
    output logic aneg_restart_o,
    output logic power_down_o,
    output logic isolate_o,
    output logic full_duplex_o,
    output logic collision_test_o,
    output logic soft_reset_o,
    output logic tx_enable_o,
    output logic [DATA_W-1:0] media_txd_o,
    output logic [DATA_W-1:0] mac_rxd_o,
    output logic mac_rx_oe_n_o,
    output logic mac_col_o
);
    localparam int SRST_CYC = `PMC_SRST_CYC;
    localparam int BW = $clog2(SRST_CYC + 1);

    logic [4:0] reg_addr;
    logic wr_stb;
    logic [15:0] wr_data;
    logic [15:0] rd_data;

    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [15:0] page_r;
    logic [BW-1:0] busy_cnt_r;
    logic restart_r;
    logic tx_en_r;
    logic [DATA_W-1:0] media_txd_r;
    logic [DATA_W-1:0] mac_rxd_r;
    logic mac_col_r;

    pmc_mdio_slave u_mgmt (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .mdc_i(mdc_i),
        .mdio_i(mdio_i),
        .phy_addr_i(phy_addr_i),
        .rd_data_i(rd_data),
        .mdio_o(mdio_o),
        .mdio_oe_n_o(mdio_oe_n_o),
        .reg_addr_o(reg_addr),
        .wr_stb_o(wr_stb),
        .wr_data_o(wr_data)
    );

    // register decode; the main page must be selected before the control word is reached
    wire busy = (busy_cnt_r != '0);
    wire page_main = (page_r == `PMC_PAGE_MAIN);
    wire wr_ctrl = wr_stb && !busy && page_main && (reg_addr == `PMC_ADDR_CTRL);
    wire wr_page = wr_stb && !busy && (reg_addr == `PMC_ADDR_PAGE);
    wire srst_req = wr_ctrl && wr_data[`PMC_B_SRST];

    // field views of the control word
    wire loop_f = ctrl_r[`PMC_B_LOOP];
    wire aneg_f = ctrl_r[`PMC_B_ANEG];
    wire pdown_f = ctrl_r[`PMC_B_PDOWN];
    wire iso_f = ctrl_r[`PMC_B_ISO];
    wire dup_f = ctrl_r[`PMC_B_DUPLEX];
    wire col_f = ctrl_r[`PMC_B_COLTEST];
    wire uni_f = ctrl_r[`PMC_B_UNIDIR];

    // default field values
    // writes during the reset hold time are dropped, the manager's wait makes this safe
    // reset hold window
    assign ctrl_nxt = srst_req ? `PMC_CTRL_RST :
                      wr_ctrl ? (wr_data & `PMC_CTRL_WMASK) : ctrl_r;

    // unidirectional only when forced full duplex
    wire uni_eff = uni_f && !aneg_f && dup_f;
    wire fiber = (media_mode_i == pmc_pkg::PMC_MEDIA_1000X) ||
                 (media_mode_i == pmc_pkg::PMC_MEDIA_100FX);
    wire tx_en_nxt = !pdown_f && !busy && (link_up_i || (uni_eff && fiber));
    wire restart_nxt = wr_ctrl && !srst_req && wr_data[`PMC_B_RESTART] &&
                       !wr_data[`PMC_B_PDOWN];
    wire [DATA_W-1:0] media_txd_nxt = (iso_f || !tx_en_r) ? '0 : mac_txd_i;
    wire [DATA_W-1:0] mac_rxd_nxt = iso_f ? '0 : (loop_f ? mac_txd_i : media_rxd_i);
    wire mac_col_nxt = !iso_f && (col_f ? mac_tx_en_i : (media_col_i && !dup_f));

    // reset bit reads one until done
    wire [15:0] ctrl_rd = {busy, ctrl_r[14:5], 5'h00};
    assign rd_data = (page_main && reg_addr == `PMC_ADDR_CTRL) ? ctrl_rd :
                     (reg_addr == `PMC_ADDR_PAGE) ? page_r : 16'h0000;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl_r <= `PMC_CTRL_RST;
            page_r <= `PMC_PAGE_MAIN;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (srst_req) page_r <= `PMC_PAGE_MAIN;
            else if (wr_page) page_r <= wr_data;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) busy_cnt_r <= '0;
        else if (srst_req) busy_cnt_r <= BW'(SRST_CYC);
        else if (busy) busy_cnt_r <= busy_cnt_r - BW'(1);
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            restart_r <= 1'b0;
            tx_en_r <= 1'b0;
            media_txd_r <= '0;
            mac_rxd_r <= '0;
            mac_col_r <= 1'b0;
        end else begin
            restart_r <= restart_nxt;
            tx_en_r <= tx_en_nxt;
            media_txd_r <= media_txd_nxt;
            mac_rxd_r <= mac_rxd_nxt;
            mac_col_r <= mac_col_nxt;
        end
    end

    assign loopback_o = loop_f;
    // speed code from bits 6 and 13
    assign speed_o = pmc_pkg::pmc_speed_t'({ctrl_r[`PMC_B_SPD_MSB], ctrl_r[`PMC_B_SPD_LSB]});
    assign aneg_en_o = aneg_f;
    assign aneg_restart_o = restart_r;
    assign power_down_o = pdown_f;
    assign isolate_o = iso_f;
    // half duplex legality is software's duty
    assign full_duplex_o = dup_f;
    assign collision_test_o = col_f;
    assign soft_reset_o = busy;
    assign tx_enable_o = tx_en_r;
    assign media_txd_o = media_txd_r;
    assign mac_rxd_o = mac_rxd_r;
    assign mac_rx_oe_n_o = iso_f;
    assign mac_col_o = mac_col_r;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    srst_defaults_a: assert property (srst_req |=> soft_reset_o && aneg_en_o && !loopback_o &&
        !isolate_o && speed_o == pmc_pkg::PMC_SPD_1000)
        else $error("software reset did not restore defaults");

    srst_self_clear_a: assert property ($rose(soft_reset_o) |-> ##99 soft_reset_o ##1 !soft_reset_o)
        else $error("software reset bit did not clear after hold time");

    loop_write_a: assert property (wr_ctrl && !srst_req |=> loopback_o == $past(wr_data[14]) &&
        rd_data[14] == loopback_o || reg_addr != `PMC_ADDR_CTRL)
        else $error("loopback bit not taken from write");

    speed_code_a: assert property (wr_ctrl && !srst_req |=>
        speed_o == pmc_pkg::pmc_speed_t'({$past(wr_data[6]), $past(wr_data[13])}))
        else $error("speed code not formed from bits 6 and 13");

    isolate_gate_a: assert property (isolate_o ##1 isolate_o |->
        mac_rx_oe_n_o && mac_rxd_o == '0 && media_txd_o == '0 && !mac_col_o)
        else $error("mac side active while isolated");

    restart_pulse_a: assert property (restart_nxt |=> aneg_restart_o ##1 !aneg_restart_o)
        else $error("restart is not a one-cycle self-clearing pulse");

    duplex_reset_a: assert property ($rose(soft_reset_o) |-> !full_duplex_o)
        else $error("duplex not half after reset");

    col_test_a: assert property (collision_test_o && mac_tx_en_i && !isolate_o |=> mac_col_o)
        else $error("collision test did not echo transmit enable");

    uni_ignored_a: assert property ((aneg_en_o || !full_duplex_o || !fiber) && !link_up_i
        |=> !tx_enable_o)
        else $error("transmit enabled without link while unidirectional ignored");

    uni_active_a: assert property (uni_eff && fiber && !power_down_o && !soft_reset_o
        |=> tx_enable_o)
        else $error("unidirectional fiber transmit not enabled");

    reserved_zero_a: assert property (reg_addr == `PMC_ADDR_CTRL && page_main |->
        rd_data[4:0] == 5'h00 && rd_data[9] == 1'b0)
        else $error("reserved or restart bits read nonzero");

    hard_reset_a: assert property ($past(srst_i) |-> aneg_en_o && !power_down_o &&
        speed_o == pmc_pkg::PMC_SPD_1000 && !collision_test_o)
        else $error("hard reset values wrong");

    pdown_quiet_a: assert property (power_down_o |=> !tx_enable_o ##1 media_txd_o == '0)
        else $error("link activity while powered down");

    page_gate_a: assert property (wr_stb && !page_main && !srst_req |=>
        ctrl_r == $past(ctrl_r))
        else $error("control word written while another page selected");

    busy_refuse_a: assert property (wr_stb && busy |=> ctrl_r == $past(ctrl_r))
        else $error("control word written during reset hold");

endmodule : pmc_mode_ctrl

/* pmc_mode_ctrl_bench.sv */
// self-checking bench for the mode control register block
`timescale 1ns/1ps
`include "pmc_map.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module pmc_mode_ctrl_bench;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic mdc;
    logic mdio_line;
    logic dev_mdio;
    logic dev_oe_n;
    pmc_pkg::pmc_media_t media_mode = pmc_pkg::PMC_MEDIA_COPPER;
    logic link_up = 1'b0;
    logic mac_tx_en = 1'b0;
    logic [7:0] mac_txd = 8'h00;
    logic media_col = 1'b0;
    logic [7:0] media_rxd = 8'h00;
    logic loopback_o;
    pmc_pkg::pmc_speed_t speed_o;
    logic aneg_en_o;
    logic aneg_restart_o;
    logic power_down_o;
    logic isolate_o;
    logic full_duplex_o;
    logic collision_test_o;
    logic soft_reset_o;
    logic tx_enable_o;
    logic [7:0] media_txd_o;
    logic [7:0] mac_rxd_o;
    logic mac_rx_oe_n_o;
    logic mac_col_o;
    int fail_count = 0;
    int checks_done = 0;
    int restart_seen = 0;
    int sr_cycles = 0;
    logic [15:0] v;
    logic [15:0] w;

    pmc_mode_ctrl #(.DATA_W(8)) pmc_mode_ctrl_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .mdc_i(mdc), .mdio_i(mdio_line), .mdio_o(dev_mdio), .mdio_oe_n_o(dev_oe_n),
        .phy_addr_i(5'h03), .media_mode_i(media_mode), .link_up_i(link_up),
        .mac_tx_en_i(mac_tx_en), .mac_txd_i(mac_txd), .media_col_i(media_col),
        .media_rxd_i(media_rxd), .loopback_o(loopback_o), .speed_o(speed_o),
        .aneg_en_o(aneg_en_o), .aneg_restart_o(aneg_restart_o), .power_down_o(power_down_o),
        .isolate_o(isolate_o), .full_duplex_o(full_duplex_o),
        .collision_test_o(collision_test_o), .soft_reset_o(soft_reset_o),
        .tx_enable_o(tx_enable_o), .media_txd_o(media_txd_o), .mac_rxd_o(mac_rxd_o),
        .mac_rx_oe_n_o(mac_rx_oe_n_o), .mac_col_o(mac_col_o));

    pmc_smi_mgr #(.HALF_CYC(5), .PHY_ADDR(5'h03)) pmc_smi_mgr_i (.ref_clk_i(ref_clk_i),
        .dev_mdio_i(dev_mdio), .dev_oe_n_i(dev_oe_n), .mdc_o(mdc), .mdio_o(mdio_line));

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // restart pulses and soft reset cycles are counted where they stand
    always @(posedge ref_clk_i) begin
        if (aneg_restart_o === 1'b1) restart_seen++;
        if (soft_reset_o === 1'b1) sr_cycles++;
    end

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] t;
        pmc_smi_mgr_i.frame(2'b01, a, d, t);
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        pmc_smi_mgr_i.frame(2'b10, a, 16'h0000, d);
    endtask : rd

    task automatic t_defaults;
        rd(`PMC_ADDR_CTRL, v);
        `CHK(v, 16'h1040)
        `CHK(full_duplex_o, 1'b0)
        `CHK(speed_o, pmc_pkg::PMC_SPD_1000)
        `CHK(aneg_en_o, 1'b1)
    endtask : t_defaults

    task automatic t_page;
        wr(`PMC_ADDR_PAGE, 16'h0001);
        rd(`PMC_ADDR_CTRL, v);
        `CHK(v, 16'h0000)
        wr(`PMC_ADDR_CTRL, 16'h0100);
        wr(`PMC_ADDR_PAGE, `PMC_PAGE_MAIN);
        rd(`PMC_ADDR_CTRL, v);
        `CHK(v, 16'h1040)
    endtask : t_page

    task automatic t_speed;
        for (int c = 0; c < 4; c++) begin
            w = 16'h0100;
            w[6] = c[1];
            w[13] = c[0];
            wr(`PMC_ADDR_CTRL, w);
            `CHK(speed_o, pmc_pkg::pmc_speed_t'(c[1:0]))
            rd(`PMC_ADDR_CTRL, v);
            `CHK(v, w)
        end
    endtask : t_speed

    task automatic t_paths;
        mac_txd <= 8'hA5;
        media_rxd <= 8'h3C;
        mac_tx_en <= 1'b1;
        wr(`PMC_ADDR_CTRL, 16'h4100);
        `CHK(loopback_o, 1'b1)
        `CHK(mac_rxd_o, 8'hA5)
        `CHK(speed_o, pmc_pkg::PMC_SPD_10)
        `CHK(full_duplex_o, 1'b1)
        wr(`PMC_ADDR_CTRL, 16'h0180);
        `CHK(collision_test_o, 1'b1)
        `CHK(mac_col_o, 1'b1)
        mac_tx_en <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        `CHK(mac_col_o, 1'b0)
        // half duplex legal: no timing or encryption unit runs here
        wr(`PMC_ADDR_CTRL, 16'h0000);
        media_col <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        `CHK(mac_col_o, 1'b1)
        wr(`PMC_ADDR_CTRL, 16'h0400);
        `CHK(mac_rx_oe_n_o, 1'b1)
        `CHK(isolate_o, 1'b1)
        `CHK(media_txd_o, 8'h00)
        `CHK(mac_rxd_o, 8'h00)
        `CHK(mac_col_o, 1'b0)
        link_up <= 1'b1;
        wr(`PMC_ADDR_CTRL, 16'h0800);
        `CHK(power_down_o, 1'b1)
        `CHK(tx_enable_o, 1'b0)
        wr(`PMC_ADDR_CTRL, 16'h0000);
        `CHK(tx_enable_o, 1'b1)
        `CHK(media_txd_o, 8'hA5)
        `CHK(mac_rxd_o, 8'h3C)
    endtask : t_paths

    task automatic t_restart;
        int n;
        n = restart_seen;
        wr(`PMC_ADDR_CTRL, 16'h1200);
        `CHK(restart_seen - n, 1)
        rd(`PMC_ADDR_CTRL, v);
        `CHK(v, 16'h1000)
    endtask : t_restart

    // every media mode against every autonegotiation and duplex setting, link down
    task automatic t_unidir;
        link_up <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                w = 16'h0020;
                w[12] = k[0];
                w[8] = k[1];
                media_mode <= pmc_pkg::pmc_media_t'(m[2:0]);
                wr(`PMC_ADDR_CTRL, w);
                `CHK(tx_enable_o, !k[0] && k[1] && m >= 2)
            end
        end
        wr(`PMC_ADDR_CTRL, 16'h0100);
        `CHK(tx_enable_o, 1'b0)
    endtask : t_unidir

    task automatic t_soft;
        int n;
        wr(`PMC_ADDR_CTRL, 16'h4100);
        n = sr_cycles;
        wr(`PMC_ADDR_CTRL, 16'h8000);
        rd(`PMC_ADDR_CTRL, v);
        `CHK(v, 16'h1040)
        `CHK(sr_cycles - n, 100)
        `CHK(loopback_o, 1'b0)
    endtask : t_soft

    // read-modify-write that also sets the reserved bits
    task automatic t_reserved;
        logic [15:0] r;
        rd(`PMC_ADDR_CTRL, r);
        wr(`PMC_ADDR_CTRL, r | 16'h001F);
        rd(`PMC_ADDR_CTRL, v);
        `CHK(v, r)
    endtask : t_reserved

    task automatic give_verdict;
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (100000) @(posedge ref_clk_i);
        fail_count++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        t_defaults();
        t_page();
        t_speed();
        t_paths();
        t_restart();
        t_unidir();
        t_soft();
        t_reserved();
        give_verdict();
    end
endmodule : pmc_mode_ctrl_bench

/* pmc_pkg.sv */
// types shared by the mode control block
package pmc_pkg;

    typedef enum logic [1:0] {
        PMC_SPD_10 = 2'h0,
        PMC_SPD_100 = 2'h1,
        PMC_SPD_1000 = 2'h2,
        PMC_SPD_RSVD = 2'h3
    } pmc_speed_t;

    typedef enum logic [2:0] {
        PMC_MEDIA_COPPER = 3'h0,
        PMC_MEDIA_PROTO = 3'h1,
        PMC_MEDIA_1000X = 3'h2,
        PMC_MEDIA_100FX = 3'h3
    } pmc_media_t;

    typedef enum logic [3:0] {
        PMC_ST_IDLE = 4'h1,
        PMC_ST_HDR = 4'h2,
        PMC_ST_TA = 4'h4,
        PMC_ST_DATA = 4'h8
    } pmc_mdio_st_t;

endpackage : pmc_pkg

/* pmc_smi_mgr.sv */
// station management controller model: clause-22 frames on the management pins
`timescale 1ns/1ps
module pmc_smi_mgr #(
    parameter int HALF_CYC = 5,
    parameter logic [4:0] PHY_ADDR = 5'h03
) (
    input wire logic ref_clk_i,
    input wire logic dev_mdio_i,
    input wire logic dev_oe_n_i,
    output logic mdc_o,
    output logic mdio_o
);
    logic drv_r = 1'b0;
    logic bit_r = 1'b1;
    // pull-up holds the line high when nobody drives it
    assign mdio_o = !dev_oe_n_i ? dev_mdio_i : (drv_r ? bit_r : 1'b1);
    initial mdc_o = 1'b0;

    // one management clock period; the line is sampled just before the rise
    task automatic bit_cyc(input logic b, input logic drv, output logic s);
        @(posedge ref_clk_i);
        bit_r <= b;
        drv_r <= drv;
        repeat (HALF_CYC) @(posedge ref_clk_i);
        s = mdio_o;
        mdc_o <= 1'b1;
        repeat (HALF_CYC) @(posedge ref_clk_i);
        mdc_o <= 1'b0;
    endtask : bit_cyc

    // mdc stands low between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] reg_a,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [13:0] hdr;
        logic s;
        logic rd;
        hdr = {2'b01, op, PHY_ADDR, reg_a};
        rd = (op == 2'b10);
        bit_cyc(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) begin
            bit_cyc(hdr[i], 1'b1, s);
        end
        bit_cyc(1'b1, !rd, s);
        bit_cyc(1'b0, !rd, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cyc(wdata[i], !rd, s);
            rdata[i] = s;
        end
        @(posedge ref_clk_i);
        drv_r <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        if (!rd && reg_a == 5'h00 && wdata[15]) begin
            repeat (100) @(posedge ref_clk_i);
        end
    endtask : frame
endmodule : pmc_smi_mgr
